// ### pfs_cs_filter.sv
// Glitch filter: the current-limit flag must hold for the filter time to count.
`timescale 1ns/1ps
module pfs_cs_filter #(
    parameter int FILT_CYC = 8
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic rawFlag,
    output logic      filtFlag
);
    import pfs_pkg::*;
    logic [7:0] holdCount;

    // Counts only while the flag stays high, so a short spike resets it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            holdCount <= 8'h00;
            filtFlag  <= 1'b0;
        end else if (!rawFlag) begin
            holdCount <= 8'h00;
            filtFlag  <= 1'b0;
        end else if (holdCount < 8'(FILT_CYC - 1)) begin
            holdCount <= holdCount + 8'h01;
        end else begin
            filtFlag  <= 1'b1;
        end
    end
endmodule : pfs_cs_filter

// ### pfs_flags_if.sv
// Interface carrying synchronised comparator flags between design modules.
`timescale 1ns/1ps
interface pfs_flags_if;
    logic csLimit;
    logic lightLoad;
    logic ssEnable;
    logic ss36;
    logic ss37;
    logic ss465;
    logic syncIn;
    logic cfgMaster;
    logic cfgSlaveLoad;
    modport src (output csLimit, lightLoad, ssEnable, ss36, ss37, ss465, syncIn,
                 cfgMaster, cfgSlaveLoad);
    modport dst (input csLimit, lightLoad, ssEnable, ss36, ss37, ss465, syncIn,
                 cfgMaster, cfgSlaveLoad);
endinterface : pfs_flags_if

// ### pfs_input_sync.sv
// Two-flop synchronisers for the six comparator inputs, the sync pin and the two straps.
`timescale 1ns/1ps
module pfs_input_sync (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [8:0] rawIn,
    pfs_flags_if.src        flags
);
    import pfs_pkg::*;
    logic [8:0] stage1;
    logic [8:0] stage2;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= 9'h000;
            stage2 <= 9'h000;
        end else begin
            stage1 <= rawIn;
            stage2 <= stage1;
        end
    end

    assign flags.csLimit      = stage2[0];
    assign flags.lightLoad    = stage2[1];
    assign flags.ssEnable     = stage2[2];
    assign flags.ss36         = stage2[3];
    assign flags.ss37         = stage2[4];
    assign flags.ss465        = stage2[5];
    assign flags.syncIn       = stage2[6];
    assign flags.cfgMaster    = stage2[7];
    assign flags.cfgSlaveLoad = stage2[8];
endmodule : pfs_input_sync

// ### pfs_mode_sync_sequencer.sv
// Top: mode selection, current limit, soft-start sequencing and sync, with APB.
`timescale 1ns/1ps
// Overview of operation
// - Hysteresis current enable is on only in light-load mode.
// - Mode changes after two consecutive PWM falling edges confirm the new condition.
// - Rectifier drives are held off in light-load mode, passed in continuous mode.
// - Current-sense pulses shorter than 30 ns are filtered away.
// - Current-limit flag ends the present power pulse each cycle.
// - Overcurrent before 3.7 V limits current while soft-start keeps charging.
// - At 3.7 V under limit, pull up to 4.65 V then discharge to time limit.
// - Strong external pull-up on soft-start latches off instead of hiccup.
// - Latch-off clears only when soft-start drops below 0.55 V, on UVLO, or when runEn is cleared.
// - Master or slave role is chosen from configuration straps.
// - Master drives sync at the switching frequency with half duty.
// - Slave never drives the sync pin.
// - Slave aligns its clock to falling edges of incoming sync.
// - Slave does not switch until one sync pulse is received.
// - Slave keeps running on its own oscillator if sync stops.
// - Master emits sync only after soft-start passes 0.55 V.
// - Slave starts its soft-start ramp without any sync pulse.
module pfs_mode_sync_sequencer #(
    parameter int PERIOD_W = 16
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        csLimitCmp,
    input  wire logic        lightLoadCmp,
    input  wire logic        ssEnableCmp,
    input  wire logic        ss36Cmp,
    input  wire logic        ss37Cmp,
    input  wire logic        ss465Cmp,
    input  wire logic        ssPullupStrong,
    input  wire logic        freqSetToRef,
    input  wire logic        ssSlaveLoad,
    input  wire logic        syncPinIn,
    output logic             syncPinOut,
    output logic             syncPinOe,
    input  wire logic        pwmFallEdge,
    input  wire logic        pwrPulseReq,
    input  wire logic        rectDriveOneIn,
    input  wire logic        rectDriveTwoIn,
    output logic             powerPulse,
    output logic             rectifierDriveOne,
    output logic             rectifierDriveTwo,
    output logic             hystCurrentEn,
    output logic             ssPullupEn,
    output logic             ssChargeEn,
    output logic             ssDischargeEn,
    output logic             switchingEn,
    output logic             localClockTick
);
    import pfs_pkg::*;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    pfs_flags_if flags ();
    logic [4:0] extSync1;
    logic [4:0] extSync2;
    logic       pullupStrong;
    logic       pwmFall;
    assign pullupStrong = extSync2[0];
    assign pwmFall      = extSync2[1];

    pfs_input_sync u_sync (
        .clk   (clk),
        .rstn  (rstn),
        .rawIn ({ssSlaveLoad, freqSetToRef, syncPinIn, ss465Cmp, ss37Cmp, ss36Cmp,
                 ssEnableCmp, lightLoadCmp, csLimitCmp}),
        .flags (flags)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extSync1 <= 5'h00;
            extSync2 <= 5'h00;
        end else begin
            extSync1 <= {rectDriveTwoIn, rectDriveOneIn, pwrPulseReq, pwmFallEdge,
                         ssPullupStrong};
            extSync2 <= extSync1;
        end
    end

    logic csFilt;
    pfs_cs_filter #(.FILT_CYC(CS_FILTER_CYC)) u_csf (
        .clk      (clk),
        .rstn     (rstn),
        .rawFlag  (flags.csLimit),
        .filtFlag (csFilt)
    );

    // ****************************************************************
    // APB registers
    // ****************************************************************
    logic                runEn;
    logic                lightLoadAllow;
    logic [PERIOD_W-1:0] periodCyc;
    logic                lightMode;
    logic                isMaster;
    logic                syncSeen;
    pfs_ss_state_t       ssState;

    wire apbAccess = psel && penable;
    wire apbWrite  = apbAccess && pwrite;
    wire hitCtrl   = (paddr == CTRL_OFFSET);
    wire hitStatus = (paddr == STATUS_OFFSET);
    wire hitPeriod = (paddr == PERIOD_OFFSET);
    wire hitAny    = hitCtrl || hitStatus || hitPeriod;
    wire [31:0] statusWord = {22'h0, 3'(ssState), syncSeen, isMaster, lightMode,
                              csFilt, switchingEn, runEn, lightLoadAllow};
    wire [31:0] readMux = hitCtrl   ? {30'h0, lightLoadAllow, runEn} :
                          hitStatus ? statusWord :
                          hitPeriod ? {{(32-PERIOD_W){1'b0}}, periodCyc} : SLV_ERR_DATA;

    // Zero-wait-state slave: pready is high in every access phase.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            runEn          <= CTRL_RESET[CTRL_RUN_BIT];
            lightLoadAllow <= CTRL_RESET[CTRL_LLE_BIT];
            periodCyc      <= PERIOD_W'(PERIOD_RESET);
        end else if (apbWrite && hitCtrl) begin
            runEn          <= pwdata[CTRL_RUN_BIT];
            lightLoadAllow <= pwdata[CTRL_LLE_BIT];
        end else if (apbWrite && hitPeriod) begin
            periodCyc      <= pwdata[PERIOD_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hitAny;
            prdata  <= (psel && !penable && !pwrite) ? readMux : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Light-load mode qualification
    // ****************************************************************
    logic [1:0] confirmCount;
    logic       pwmFallD;
    wire        pwmFallPulse = !pwmFall && pwmFallD;
    wire        wantLight    = flags.lightLoad && lightLoadAllow;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwmFallD     <= 1'b0;
            confirmCount <= 2'h0;
            lightMode    <= 1'b0;
        end else begin
            pwmFallD <= pwmFall;
            if (wantLight == lightMode) begin
                confirmCount <= 2'h0;
            end else if (pwmFallPulse) begin
                if (confirmCount == 2'(MODE_CONFIRM - 1)) begin
                    lightMode    <= wantLight;
                    confirmCount <= 2'h0;
                end else begin
                    confirmCount <= confirmCount + 2'h1;
                end
            end
        end
    end

    // ****************************************************************
    // Role and sync
    // ****************************************************************
    logic                roleCaught;
    logic [1:0]          roleWait;
    logic [PERIOD_W-1:0] oscCount;
    logic [PERIOD_W:0]   lossCount;
    logic                syncInD;
    logic                syncOutLvl;
    wire                 syncFall   = syncInD && !flags.syncIn;
    wire [PERIOD_W-1:0]  halfPeriod = periodCyc >> 1;
    wire                 oscWrap    = (oscCount >= periodCyc - PERIOD_W'(1));
    wire                 syncLive   = (lossCount < {periodCyc, 1'b0});

    // Role is caught once the strap synchronisers hold real values, then held.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            roleWait   <= 2'h0;
            roleCaught <= 1'b0;
            isMaster   <= 1'b0;
        end else if (roleWait != 2'h2) begin
            roleWait   <= roleWait + 2'h1;
        end else if (!roleCaught) begin
            roleCaught <= 1'b1;
            isMaster   <= flags.cfgMaster || !flags.cfgSlaveLoad;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncInD   <= 1'b0;
            syncSeen  <= 1'b0;
            oscCount  <= '0;
            lossCount <= '0;
        end else begin
            syncInD <= flags.syncIn;
            if (!isMaster && syncFall) begin
                syncSeen  <= 1'b1;
                oscCount  <= '0;
                lossCount <= '0;
            end else begin
                oscCount  <= oscWrap ? '0 : oscCount + PERIOD_W'(1);
                if (syncLive) begin
                    lossCount <= lossCount + (PERIOD_W+1)'(1);
                end
            end
        end
    end

    // Sync toggles each half period: one pulse per switching cycle.
    wire syncAllowed = isMaster && roleCaught && flags.ssEnable;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncOutLvl     <= 1'b0;
            syncPinOut     <= 1'b0;
            syncPinOe      <= 1'b0;
            localClockTick <= 1'b0;
        end else begin
            syncOutLvl     <= syncAllowed && (oscCount < halfPeriod);
            syncPinOut     <= syncOutLvl;
            syncPinOe      <= syncAllowed;
            localClockTick <= oscWrap || (!isMaster && syncFall);
        end
    end

    // ****************************************************************
    // Soft-start and current-limit sequencing
    // ****************************************************************
    pfs_ss_state_t nextSsState;
    always_comb begin
        nextSsState = ssState;
        case (ssState)
            SS_IDLE:    if (runEn && roleCaught) nextSsState = SS_RAMP;
            SS_RAMP:    if (flags.ss37) nextSsState = csFilt ? SS_PULLUP : SS_RUN;
            SS_RUN:     if (csFilt) nextSsState = SS_PULLUP;
            SS_PULLUP:  if (flags.ss465) nextSsState = SS_LIMIT;
            SS_LIMIT:   if (!flags.ss37) nextSsState = pullupStrong ? SS_LATCHED
                                                                    : SS_HICCUP;
            SS_HICCUP:  if (!flags.ssEnable) nextSsState = SS_RAMP;
            SS_LATCHED: if (!flags.ssEnable) nextSsState = SS_RAMP;
            default:    nextSsState = SS_IDLE;
        endcase
        if (!runEn) begin
            nextSsState = SS_IDLE;
        end
    end

    wire limitActive = (ssState == SS_PULLUP) || (ssState == SS_LIMIT);
    wire stateOn     = (ssState == SS_RAMP) || (ssState == SS_RUN) || limitActive;
    wire slaveReady  = isMaster || syncSeen;
    wire switchOn    = stateOn && flags.ssEnable && slaveReady;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ssState           <= SS_IDLE;
            ssPullupEn        <= 1'b0;
            ssChargeEn        <= 1'b0;
            ssDischargeEn     <= 1'b0;
            switchingEn       <= 1'b0;
            powerPulse        <= 1'b0;
            rectifierDriveOne <= 1'b0;
            rectifierDriveTwo <= 1'b0;
            hystCurrentEn     <= 1'b0;
        end else begin
            ssState           <= nextSsState;
            ssPullupEn        <= (nextSsState == SS_PULLUP);
            ssChargeEn        <= (nextSsState == SS_RAMP) || (nextSsState == SS_RUN)
                                 || (nextSsState == SS_HICCUP && pullupStrong == 1'b0);
            ssDischargeEn     <= (nextSsState == SS_LIMIT) || (nextSsState == SS_HICCUP);
            switchingEn       <= switchOn;
            powerPulse        <= switchOn && extSync2[2] && !csFilt;
            rectifierDriveOne <= switchOn && !lightMode && extSync2[3];
            rectifierDriveTwo <= switchOn && !lightMode && extSync2[4];
            hystCurrentEn     <= lightMode;
        end
    end
endmodule : pfs_mode_sync_sequencer

// ### pfs_mode_sync_sequencer_bench.sv
// Self-checking bench for the mode, soft-start and sync sequencer.
`timescale 1ns/1ps
module pfs_mode_sync_sequencer_bench;
    import pfs_pkg::*;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err, low;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        csLimitCmp, lightLoadCmp, ssEnableCmp, ss36Cmp, ss37Cmp, ss465Cmp;
    logic        ssPullupStrong, freqSetToRef, ssSlaveLoad, syncPinOut, syncPinOe;
    logic        pwmFallEdge, pwrPulseReq, rectDriveOneIn, rectDriveTwoIn, powerPulse;
    logic        rectifierDriveOne, rectifierDriveTwo, hystCurrentEn, ssPullupEn;
    logic        ssChargeEn, ssDischargeEn, switchingEn, localClockTick;
    logic        peerRun, peerOut, peerOe;
    logic [6:0]  watch;
    wire         syncPinIn;
    int          failures = 0, check_count = 0, t1, t2;
    // The shared line rests low through the receiver bias when nobody drives it.
    assign syncPinIn = (syncPinOe & syncPinOut) | (peerOe & peerOut);
    assign watch = {syncPinIn, localClockTick, syncPinOut, syncPinOe, switchingEn, ssPullupEn,
                    ssDischargeEn};
    pfs_mode_sync_sequencer dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .csLimitCmp, .lightLoadCmp, .ssEnableCmp, .ss36Cmp, .ss37Cmp,
        .ss465Cmp, .ssPullupStrong, .freqSetToRef, .ssSlaveLoad, .syncPinIn, .syncPinOut,
        .syncPinOe, .pwmFallEdge, .pwrPulseReq, .rectDriveOneIn, .rectDriveTwoIn, .powerPulse,
        .rectifierDriveOne, .rectifierDriveTwo, .hystCurrentEn, .ssPullupEn, .ssChargeEn,
        .ssDischargeEn, .switchingEn, .localClockTick);
    pfs_sync_peer peer (.peerRun, .peerOut, .peerOe);
    always #2 clk = ~clk;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic report_and_stop;
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    task automatic wait_on(input int idx, input logic val);
        int k;
        k = 0;
        while (watch[idx] !== val && k < 4000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 4000) begin
            failures++;
            report_and_stop();
        end
    endtask : wait_on
    task automatic span(input int idx, input logic val, output int len);
        wait_on(idx, val);
        len = 0;
        while (watch[idx] === val && len < 4000) begin
            @(posedge clk);
            len++;
        end
        if (len >= 4000) begin
            failures++;
            report_and_stop();
        end
    endtask : span
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 100) begin
            failures++;
            report_and_stop();
        end
    endtask : apb
    task automatic wait_state(input logic eq, input pfs_ss_state_t st);
        int k;
        k = 0;
        do begin
            apb(1'b0, STATUS_OFFSET, 32'h0);
            k++;
        end while ((rd[9:7] === 3'(st)) !== eq && k < 300);
        check(32'(k < 300), 32'h1);
        if (k >= 300) begin
            report_and_stop();
        end
    endtask : wait_state
    task automatic pwm_fall;
        @(posedge clk);
        pwmFallEdge <= 1'b1;
        cyc(4);
        pwmFallEdge <= 1'b0;
        cyc(12);
    endtask : pwm_fall
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {clk, rstn, psel, penable, pwrite, paddr, pwdata, csLimitCmp, lightLoadCmp, ssEnableCmp,
         ss36Cmp, ss37Cmp, ss465Cmp, ssPullupStrong, ssSlaveLoad, pwmFallEdge, peerRun} = '0;
        {freqSetToRef, pwrPulseReq, rectDriveOneIn, rectDriveTwoIn} = '1;
        cyc(20);
        rstn <= 1'b1;
        cyc(3);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, CTRL_RESET);
        apb(1'b0, PERIOD_OFFSET, 32'h0);
        check(rd, 32'(PERIOD_RESET));
        apb(1'b0, 8'h3C, 32'h0);
        check({rd[30:0], err}, {SLV_ERR_DATA[30:0], 1'b1});
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(32'(rd[5]), 32'h1);
        cyc(100);
        check(32'(syncPinOe), 32'h0);
        ssEnableCmp <= 1'b1;
        wait_on(3, 1'b1);
        span(4, 1'b1, t1);
        span(4, 1'b1, t1);
        span(4, 1'b0, t2);
        check(32'(t1), 32'(PERIOD_RESET / 2));
        check(32'(t2), 32'(PERIOD_RESET / 2));
        wait_on(2, 1'b1);
        for (int m = 1; m >= 0; m--) begin
            lightLoadCmp <= m[0];
            pwm_fall();
            check(32'({hystCurrentEn, rectifierDriveOne}), 32'({!m[0], m[0]}));
            pwm_fall();
            check(32'({hystCurrentEn, rectifierDriveOne, rectifierDriveTwo}),
                  32'({m[0], !m[0], !m[0]}));
        end
        // A 28 ns pulse sits just under the filter time.
        csLimitCmp <= 1'b1;
        cyc(7);
        csLimitCmp <= 1'b0;
        low = 1'b0;
        repeat (20) begin
            @(posedge clk);
            low = low | !powerPulse;
        end
        check(32'(low), 32'h0);
        for (int s = 1; s >= 0; s--) begin
            ssPullupStrong <= s[0];
            ssEnableCmp    <= 1'b1;
            ss36Cmp        <= 1'b1;
            csLimitCmp     <= 1'b1;
            cyc(20);
            check(32'({powerPulse, ssChargeEn}), 32'h1);
            ss37Cmp <= 1'b1;
            wait_on(1, 1'b1);
            ss465Cmp <= 1'b1;
            wait_on(0, 1'b1);
            check(32'(ssPullupEn), 32'h0);
            {ss36Cmp, ss37Cmp, ss465Cmp, csLimitCmp} <= '0;
            wait_state(1'b1, s[0] ? SS_LATCHED : SS_HICCUP);
            cyc(50);
            wait_state(1'b1, s[0] ? SS_LATCHED : SS_HICCUP);
            check(32'(switchingEn), 32'h0);
            ssEnableCmp <= 1'b0;
            wait_state(1'b0, s[0] ? SS_LATCHED : SS_HICCUP);
        end
        rstn <= 1'b0;
        freqSetToRef <= 1'b0;
        ssSlaveLoad <= 1'b1;
        ssEnableCmp <= 1'b1;
        cyc(20);
        rstn <= 1'b1;
        cyc(200);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(32'(rd[5]), 32'h0);
        check(32'({ssChargeEn, switchingEn, syncPinOe}), 32'h4);
        peerRun <= 1'b1;
        wait_on(2, 1'b1);
        wait_on(6, 1'b1);
        wait_on(6, 1'b0);
        span(5, 1'b0, t1);
        wait_on(6, 1'b1);
        wait_on(6, 1'b0);
        span(5, 1'b0, t2);
        check(32'(t1), 32'(t2));
        peerRun <= 1'b0;
        cyc(300);
        check(32'(switchingEn), 32'h1);
        wait_on(5, 1'b1);
        span(5, 1'b0, t1);
        check(32'(t1 + 1), 32'(PERIOD_RESET));
        report_and_stop();
    end
endmodule : pfs_mode_sync_sequencer_bench

// ### pfs_pkg.sv
// Package of shared constants and types for the phase-shifted full-bridge sequencer.
package pfs_pkg;
    // ****************************************************************
    // Register map (APB, byte addresses)
    // ****************************************************************
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] PERIOD_OFFSET = 8'h08;
    localparam int         CTRL_RUN_BIT  = 0;
    localparam int         CTRL_LLE_BIT  = 1;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0003;
    localparam logic [15:0] PERIOD_RESET = 16'h0040;
    localparam logic [31:0] SLV_ERR_DATA = 32'h0000_0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int CS_FILTER_PS    = 30000;
    localparam int CS_FILTER_CYC   = (CS_FILTER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MODE_CONFIRM    = 2;
    localparam int SYNC_LOSS_MULT  = 2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum {
        SS_IDLE, SS_RAMP, SS_RUN, SS_PULLUP, SS_LIMIT, SS_HICCUP, SS_LATCHED
    } pfs_ss_state_t;
endpackage : pfs_pkg

// ### pfs_seq_monitor.sv
// Concurrent checks on the sequencer top-level ports, bound to the top module.
`timescale 1ns/1ps
module pfs_seq_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic csLimitCmp,
    input wire logic lightLoadCmp,
    input wire logic ssEnableCmp,
    input wire logic ss37Cmp,
    input wire logic ss465Cmp,
    input wire logic freqSetToRef,
    input wire logic ssSlaveLoad,
    input wire logic syncPinIn,
    input wire logic syncPinOe,
    input wire logic pwmFallEdge,
    input wire logic powerPulse,
    input wire logic rectifierDriveOne,
    input wire logic rectifierDriveTwo,
    input wire logic hystCurrentEn,
    input wire logic ssPullupEn,
    input wire logic switchingEn,
    input wire logic localClockTick
);
    // ****************************************************************
    // Helper state
    // ****************************************************************
    // Edges are seen here before the design's synchronisers, so counts only err high.
    logic       slave;
    logic       syncSeen;
    logic [1:0] falls;
    logic [7:0] tickGap;
    assign slave = !freqSetToRef && ssSlaveLoad;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncSeen <= 1'b0;
            falls    <= 2'h0;
            tickGap  <= 8'h00;
        end else begin
            syncSeen <= syncSeen || $fell(syncPinIn);
            falls    <= $changed(lightLoadCmp) ? 2'h0 :
                        ($fell(pwmFallEdge) && falls != 2'h3) ? falls + 2'h1 : falls;
            tickGap  <= localClockTick ? 8'h00 : (tickGap == 8'hFF ? tickGap : tickGap + 8'h01);
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking mcb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_apb_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_cs_long;
        csLimitCmp [*8] ##1 csLimitCmp [*8];
    endsequence
    a_apb_ready: assert property (s_apb_access |-> pready)
        else $error("no ready in the first access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_hyst_mode: assert property (hystCurrentEn |-> !rectifierDriveOne && !rectifierDriveTwo)
        else $error("rectifier drive active with hysteresis current on");
    a_mode_confirm: assert property ($changed(hystCurrentEn) |-> falls >= 2'h2)
        else $error("mode changed before two falling PWM edges");
    a_cs_limit: assert property (s_cs_long |-> !powerPulse)
        else $error("power pulse kept during sustained current limit");
    a_pullup_stop: assert property (ss465Cmp [*8] |-> !ssPullupEn)
        else $error("soft-start pull-up kept above upper level");
    a_pullup_cause: assert property ($rose(ssPullupEn) |-> ss37Cmp)
        else $error("soft-start pull-up without the 3.7 V level");
    a_slave_quiet: assert property (slave |-> !syncPinOe)
        else $error("slave drives the sync pin");
    a_sync_gate: assert property (!ssEnableCmp [*8] |=> !syncPinOe)
        else $error("sync driven below the enable level");
    a_slave_start: assert property (slave && switchingEn |-> syncSeen)
        else $error("slave switching before any sync pulse");
    a_slave_align: assert property (slave && $fell(syncPinIn) |-> ##[1:80] localClockTick)
        else $error("no clock tick after a sync falling edge");
    a_osc_freerun: assert property (tickGap < 8'd140)
        else $error("local oscillator stopped");
endmodule : pfs_seq_monitor

bind pfs_mode_sync_sequencer pfs_seq_monitor u_monitor (.clk, .rstn, .psel, .penable, .pready,
    .pslverr, .csLimitCmp, .lightLoadCmp, .ssEnableCmp, .ss37Cmp, .ss465Cmp, .freqSetToRef,
    .ssSlaveLoad, .syncPinIn, .syncPinOe, .pwmFallEdge, .powerPulse, .rectifierDriveOne,
    .rectifierDriveTwo, .hystCurrentEn, .ssPullupEn, .switchingEn, .localClockTick);

// ### pfs_sync_peer.sv
// Peer controller acting as sync master on the shared sync line.
`timescale 1ns/1ps
module pfs_sync_peer #(
    parameter int HALF_NS = 40
) (
    input  wire logic peerRun,
    output logic      peerOut,
    output logic      peerOe
);
    // ****************************************************************
    // Pulse source
    // ****************************************************************
    // An 80 ns period is far above 1.8 times the slave frequency under test.
    // The odd start offset keeps the pulse edges clear of the bench clock edges.
    // Taken as a master whose soft-start is already past its enable level.
    initial begin
        peerOut = 1'b0;
        peerOe  = 1'b0;
        #13;
        forever begin
            #(HALF_NS);
            peerOe  = peerRun;
            peerOut = peerRun && !peerOut;
        end
    end
endmodule : pfs_sync_peer
